// ===== epcs_core.sv
// Encoder profile cyclic control and status word handler
// Operation
// - Status bits 1,0 both set means CCW increases counts, otherwise CW.
// - Extended class bit clear disables code sequence, preset and scaling.
// - Preset allowed only when status bit 1 set and bit 2 clear.
// - Scaling allowed only when status bits 1 and 3 both set.
// - Bit 4 clear sends only comms alarms; set adds encoder faults.
// - Status bit 5 clear when configuration is V3.1 compatible.
// - Supported faults always set; active fault bits follow live faults.
// - Only sensor control bits 15 to 11 are used.
// - Mode bit clear: offset adjusted so position equals preset.
// - Mode bit set: preset value added to the offset.
// - Preset starts on rising request bit, using stored preset value.
// - Done bit set after preset applied.
// - Second position word shows position when requested, else zero; error overrides.
// - Park bit puts device parked; controller then ignores position.
// - While parked, pending errors clear and removal alarm suppressed.
// - Acknowledge bit clears the acknowledgement-required flag.
// - Sensor error bit stays while the error persists.
// - Only encoder control bits 15 to 12 and 10 are used.
// - Device monitors controller sign-of-life count.
// - Controller data valid only with control-by-PLC bit set.
// - Handshake applies only in V4.1 mode; V3.1 always accepts.
// - Status bit 13 marks position, bit 15 marks error code.
// - Parked bit set during initialisation and on park command.
`timescale 1ns/100ps
`default_nettype none
module epcs_core
   import epcs_pkg::*;
#(
   parameter int FAULT_W = 32
)
(
   input wire logic i_mclk,
   input wire logic i_srst,
   input wire logic i_exchange,
   input wire logic [15:0] i_sensor_ctrl,
   input wire logic [15:0] i_encoder_ctrl,
   input wire logic [31:0] i_preset_value,
   input wire logic [31:0] i_raw_position,
   input wire logic [31:0] i_error_code,
   input wire logic [FAULT_W-1:0] i_fault_live,
   input wire logic i_init_done,
   input wire logic i_cfg_ext_class,
   input wire logic i_cfg_code_ccw,
   input wire logic i_cfg_preset_inhibit,
   input wire logic i_cfg_scaling,
   input wire logic i_cfg_alarm_enc,
   input wire logic i_cfg_v41,
   input wire logic i_comm_alarm,
   output logic [31:0] o_operating_status_flags,
   output logic [FAULT_W-1:0] o_faults_active,
   output logic [FAULT_W-1:0] o_faults_supported,
   output logic [15:0] o_sensor_status,
   output logic [15:0] o_encoder_status,
   output logic [31:0] o_position,
   output logic [31:0] o_position2,
   output logic [31:0] o_offset,
   output logic o_count_ccw,
   output logic o_scaling_en,
   output logic o_alarm,
   output logic o_removal_alarm_en,
   output logic o_ctrl_stable
);
   typedef struct packed {
      logic [15:0] scw_prev;
      logic [31:0] offset;
      logic [31:0] ops;
      logic [FAULT_W-1:0] fa;
      logic [FAULT_W-1:0] fs;
      logic [15:0] ssw;
      logic [15:0] esw;
      logic [31:0] pos;
      logic [31:0] pos2;
      logic ccw;
      logic scale;
      logic alarm;
      logic rm_alarm;
      logic stable;
   } epcs_state_t;
   epcs_state_t s_q, s_d;

   logic life_ok;
   logic [15:0] scw, ecw;
   logic accept, sensor_err, parked, preset_ok, req_rise;
   logic [31:0] cur_pos;

   epcs_life_mon u_life (
      .i_mclk(i_mclk),
      .i_srst(i_srst),
      .i_step(i_exchange),
      .i_life(ecw[15:ECW_LIFE_LO]),
      .o_stable(life_ok)
   );

   always_comb begin
      scw = i_sensor_ctrl & SCW_USED_MASK;
      ecw = i_encoder_ctrl & ECW_USED_MASK;
      // V3.1 mode ignores the control handshake entirely
      accept = !i_cfg_v41 || ecw[ECW_PLC];
      parked = !i_init_done || (accept && scw[SCW_PARK]);
      sensor_err = (|i_fault_live) && !parked;
      preset_ok = i_cfg_ext_class && !i_cfg_preset_inhibit;
      req_rise = accept && scw[SCW_REQ] && !s_q.scw_prev[SCW_REQ];
      cur_pos = i_raw_position + s_q.offset;
   end

   always_comb begin
      s_d = s_q;
      s_d.ops = '0;
      s_d.ops[OPS_CODE_SEQ] = i_cfg_code_ccw;
      s_d.ops[OPS_EXT_CLASS] = i_cfg_ext_class;
      s_d.ops[OPS_PRESET_INH] = i_cfg_preset_inhibit;
      s_d.ops[OPS_SCALING] = i_cfg_scaling;
      s_d.ops[OPS_ALARM_ENC] = i_cfg_alarm_enc;
      s_d.ops[OPS_COMPAT_OFF] = i_cfg_v41;
      s_d.ccw = i_cfg_ext_class && i_cfg_code_ccw;
      s_d.scale = i_cfg_ext_class && i_cfg_scaling;
      s_d.fs = FAULTS_SUPPORTED[FAULT_W-1:0];
      s_d.fa = parked ? '0 : (i_fault_live & FAULTS_SUPPORTED[FAULT_W-1:0]);
      s_d.alarm = !parked && (i_comm_alarm || (i_cfg_alarm_enc && sensor_err));
      s_d.rm_alarm = !parked;
      s_d.stable = life_ok;
      s_d.ssw[SSW_PARK] = parked;
      s_d.ssw[SSW_ERR] = sensor_err;
      s_d.esw = '0;
      s_d.esw[ESW_CTRL_REQ] = i_cfg_v41 && i_init_done;
      s_d.esw[ESW_FAULT] = sensor_err;
      s_d.pos = cur_pos;
      // The error bit moves every cycle, so a new error is caught here and not only at an exchange
      // A raise wins over a same-step acknowledge
      if (sensor_err && !s_q.ssw[SSW_ERR]) begin
         s_d.ssw[SSW_ACKREQ] = 1'b1;
      end else if (parked || (i_exchange && accept && scw[SCW_ACK])) begin
         s_d.ssw[SSW_ACKREQ] = 1'b0;
      end
      if (i_exchange) begin
         s_d.scw_prev = accept ? scw : s_q.scw_prev;
         if (!scw[SCW_REQ]) begin
            s_d.ssw[SSW_DONE] = 1'b0;
         end
         if (req_rise && preset_ok && !parked) begin
            // Absolute preset lands the present reading on the preset value
            if (scw[SCW_MODE]) begin
               s_d.offset = s_q.offset + i_preset_value;
            end else begin
               s_d.offset = i_preset_value - i_raw_position;
            end
            s_d.ssw[SSW_DONE] = 1'b1;
         end
         if (sensor_err) begin
            s_d.pos2 = i_error_code;
            s_d.ssw[SSW_ABS] = 1'b0;
         end else if (accept && scw[SCW_ABS] && !parked) begin
            s_d.pos2 = cur_pos;
            s_d.ssw[SSW_ABS] = 1'b1;
         end else begin
            s_d.pos2 = '0;
            s_d.ssw[SSW_ABS] = 1'b0;
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         s_q <= '0;
         // Supported set is a fixed property, so it stands through reset too
         s_q.fs <= FAULTS_SUPPORTED[FAULT_W-1:0];
         s_q.offset <= OFFSET_RST;
         s_q.ssw <= WORD_RST;
         s_q.ssw[SSW_PARK] <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_operating_status_flags = s_q.ops;
   assign o_faults_active = s_q.fa;
   assign o_faults_supported = s_q.fs;
   assign o_sensor_status = s_q.ssw;
   assign o_encoder_status = s_q.esw;
   assign o_position = s_q.pos;
   assign o_position2 = s_q.pos2;
   assign o_offset = s_q.offset;
   assign o_count_ccw = s_q.ccw;
   assign o_scaling_en = s_q.scale;
   assign o_alarm = s_q.alarm;
   assign o_removal_alarm_en = s_q.rm_alarm;
   assign o_ctrl_stable = s_q.stable;

   // Registered flags lag their inputs by one cycle; the first edge after reset still shows reset values
   ccw_needs_ext_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      o_count_ccw |-> $past(i_cfg_ext_class) && $past(i_cfg_code_ccw))
      else $error("ccw without extended class");
   ccw_flag_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      !$past(i_srst) |-> o_count_ccw == ($past(i_cfg_ext_class) && $past(i_cfg_code_ccw)))
      else $error("counting direction wrong");
   scale_gate_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      !$past(i_srst) |-> o_scaling_en == ($past(i_cfg_ext_class) && $past(i_cfg_scaling)))
      else $error("scaling enable wrong");
   ops_code_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      !$past(i_srst) |-> o_operating_status_flags[OPS_CODE_SEQ] == $past(i_cfg_code_ccw))
      else $error("code sequence bit wrong");
   ops_ext_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      !$past(i_srst) |-> o_operating_status_flags[OPS_EXT_CLASS] == $past(i_cfg_ext_class))
      else $error("extended class bit wrong");
   ops_inhibit_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      !$past(i_srst) |-> o_operating_status_flags[OPS_PRESET_INH] == $past(i_cfg_preset_inhibit))
      else $error("preset control bit wrong");
   ops_scaling_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      !$past(i_srst) |-> o_operating_status_flags[OPS_SCALING] == $past(i_cfg_scaling))
      else $error("scaling control bit wrong");
   ops_alarm_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      !$past(i_srst) |-> o_operating_status_flags[OPS_ALARM_ENC] == $past(i_cfg_alarm_enc))
      else $error("alarm channel bit wrong");
   compat_bit_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      !$past(i_srst) |-> o_operating_status_flags[OPS_COMPAT_OFF] == $past(i_cfg_v41))
      else $error("compat bit wrong");
   ops_upper_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      o_operating_status_flags[31:OPS_COMPAT_OFF+1] == '0)
      else $error("unused status bits set");
   // Fault words
   faults_sup_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      o_faults_supported == FAULTS_SUPPORTED[FAULT_W-1:0])
      else $error("supported faults changed");
   fault_mask_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      (o_faults_active & ~FAULTS_SUPPORTED[FAULT_W-1:0]) == '0)
      else $error("unsupported fault reported");
   fault_live_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      !parked |=> o_faults_active == ($past(i_fault_live) & FAULTS_SUPPORTED[FAULT_W-1:0]))
      else $error("active faults wrong");
   // Preset handshake
   preset_done_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      (i_exchange && req_rise && preset_ok && !parked && !scw[SCW_MODE])
      |=> o_sensor_status[SSW_DONE] && o_offset == $past(i_preset_value) - $past(i_raw_position))
      else $error("absolute preset not applied");
   rel_preset_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      (i_exchange && req_rise && preset_ok && !parked && scw[SCW_MODE])
      |=> o_sensor_status[SSW_DONE] && o_offset == $past(o_offset) + $past(i_preset_value))
      else $error("relative preset not applied");
   pos_track_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      !$past(i_srst) |-> o_position == $past(i_raw_position) + $past(o_offset))
      else $error("position does not follow offset");
   no_preset_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      !preset_ok |=> o_offset == $past(o_offset))
      else $error("offset moved while preset forbidden");
   ext_hold_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      !i_cfg_ext_class |=> o_offset == $past(o_offset))
      else $error("offset moved without extended class");
   done_gate_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      (i_exchange && req_rise && !preset_ok) |=> !o_sensor_status[SSW_DONE])
      else $error("done reported for refused preset");
   edge_only_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      !(i_exchange && req_rise) |=> o_offset == $past(o_offset))
      else $error("offset moved without request edge");
   done_clear_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      (i_exchange && !scw[SCW_REQ]) |=> !o_sensor_status[SSW_DONE])
      else $error("done bit not withdrawn");
   deny_hold_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      (i_cfg_v41 && !ecw[ECW_PLC]) |=> o_offset == $past(o_offset))
      else $error("offset moved on unaccepted data");
   ctrl_req_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      !$past(i_srst) |-> o_encoder_status[ESW_CTRL_REQ] == ($past(i_cfg_v41) && $past(i_init_done)))
      else $error("control requested bit wrong");
   // Second position word and error handshake
   abs_zero_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      (i_exchange && !sensor_err && !(accept && scw[SCW_ABS])) |=> o_position2 == 32'h0)
      else $error("position2 not zero");
   abs_pos_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      (i_exchange && !sensor_err && accept && scw[SCW_ABS] && !parked)
      |=> o_position2 == $past(cur_pos) && o_sensor_status[SSW_ABS])
      else $error("position2 not the position");
   err_code_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      (i_exchange && sensor_err) |=> o_position2 == $past(i_error_code) && !o_sensor_status[SSW_ABS])
      else $error("error code not shown");
   err_flag_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      !$past(i_srst) |-> o_sensor_status[SSW_ERR] == $past(sensor_err))
      else $error("sensor error bit wrong");
   ack_raise_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      (sensor_err && !o_sensor_status[SSW_ERR]) |=> o_sensor_status[SSW_ACKREQ])
      else $error("new error not flagged");
   ack_clear_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      (i_exchange && accept && scw[SCW_ACK] && !(sensor_err && !o_sensor_status[SSW_ERR]))
      |=> !o_sensor_status[SSW_ACKREQ])
      else $error("ack did not clear flag");
   // Park and alarms
   park_bit_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      !i_init_done |=> o_sensor_status[SSW_PARK] && o_faults_active == '0)
      else $error("not parked during init");
   park_cmd_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      (accept && scw[SCW_PARK]) |=> o_sensor_status[SSW_PARK])
      else $error("park command ignored");
   park_quiet_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      o_sensor_status[SSW_PARK] |-> !o_sensor_status[SSW_ERR] && !o_sensor_status[SSW_ACKREQ] && !o_alarm
         && !o_removal_alarm_en && o_faults_active == '0)
      else $error("errors shown while parked");
   rm_alarm_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      !parked |=> o_removal_alarm_en)
      else $error("removal alarm not enabled");
   alarm_off_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      (!i_cfg_alarm_enc && !i_comm_alarm) |=> !o_alarm)
      else $error("encoder fault sent without alarm bit");
   comm_alarm_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      (i_comm_alarm && !parked) |=> o_alarm)
      else $error("communication alarm not sent");
   reset_state_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      $past(i_srst) |-> o_sensor_status[SSW_PARK] && !o_sensor_status[SSW_DONE] && !o_sensor_status[SSW_ACKREQ]
         && o_offset == OFFSET_RST)
      else $error("reset state wrong");
endmodule : epcs_core
`default_nettype wire

// ===== epcs_core_test.sv
// Self-checking bench for the encoder profile control and status core
`timescale 1ns/100ps
`default_nettype none
module epcs_core_test
   import epcs_pkg::*;
;
   logic clk, rst, go, deny, bad, exch, init, ext, ccw, inh, scl, alm, v41, calm;
   logic occw, oscl, oalm, orem, ostab;
   logic [15:0] scw, sctl, ectl, sst, est;
   logic [31:0] pre, raw, ecode, flt, ops, fact, fsup, pos, pos2, off;
   int mismatches, num_checks;
   epcs_plc_model PLC (.i_mclk(clk), .i_go(go), .i_scw(scw), .i_ctrl_req(est[ESW_CTRL_REQ]), .i_deny(deny),
      .i_life_bad(bad), .o_exchange(exch), .o_sensor_ctrl(sctl), .o_encoder_ctrl(ectl));
   epcs_core DUT (.i_mclk(clk), .i_srst(rst), .i_exchange(exch), .i_sensor_ctrl(sctl), .i_encoder_ctrl(ectl),
      .i_preset_value(pre), .i_raw_position(raw), .i_error_code(ecode), .i_fault_live(flt), .i_init_done(init),
      .i_cfg_ext_class(ext), .i_cfg_code_ccw(ccw), .i_cfg_preset_inhibit(inh), .i_cfg_scaling(scl),
      .i_cfg_alarm_enc(alm), .i_cfg_v41(v41), .i_comm_alarm(calm), .o_operating_status_flags(ops),
      .o_faults_active(fact), .o_faults_supported(fsup), .o_sensor_status(sst), .o_encoder_status(est),
      .o_position(pos), .o_position2(pos2), .o_offset(off), .o_count_ccw(occw), .o_scaling_en(oscl),
      .o_alarm(oalm), .o_removal_alarm_en(orem), .o_ctrl_stable(ostab));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   // One exchange; returns once even the position word has settled
   task automatic xchg(input logic [15:0] w);
      scw = w;
      go = 1'b1;
      tick(1);
      go = 1'b0;
      tick(2);
   endtask : xchg
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_sim
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      #200000;
      mismatches++;
      end_sim();
   end
   initial begin
      {rst, go, deny, bad, init, ext, ccw, inh, scl, alm, v41} = 11'h400;
      calm = 1'b0;
      {scw, pre, raw, ecode, flt} = {16'h0000, 32'h000003e8, 32'h00000064, 32'h0000bad0, 32'h00000000};
      tick(8);
      rst = 1'b0;
      tick(1);
      chk(sst, 16'h4000);
      chk(off, 32'h0);
      chk(fsup, FAULTS_SUPPORTED);
      for (int i = 0; i < 64; i++) begin
         {v41, alm, scl, inh, ext, ccw} = i[5:0];
         tick(2);
         chk(ops, {26'h0, i[5:0]});
         chk(occw, ext && ccw);
         chk(oscl, ext && scl);
      end
      {init, ext, inh, v41, alm} = 5'b11100;
      xchg(16'h07ff);
      chk(sst, 16'h0000);
      xchg(16'h1000);
      chk(off, 32'h0);
      xchg(16'h0000);
      {ext, inh} = 2'b00;
      xchg(16'h1000);
      chk(off, 32'h0);
      xchg(16'h0000);
      ext = 1'b1;
      xchg(16'h1000);
      chk(off, 32'h384);
      chk(sst, 16'h1000);
      chk(pos, 32'h3e8);
      pre = 32'h5;
      xchg(16'h1000);
      chk(off, 32'h384);
      xchg(16'h0000);
      chk(sst, 16'h0000);
      xchg(16'h1800);
      chk(off, 32'h389);
      chk(pos, 32'h3ed);
      xchg(16'h2000);
      chk(sst, 16'h2000);
      chk(pos2, 32'h3ed);
      xchg(16'h0000);
      chk(pos2, 32'h0);
      flt = 32'h1;
      xchg(16'h2000);
      chk(sst, 16'h8800);
      chk(pos2, ecode);
      chk(fact, 32'h1);
      chk(oalm, 1'b0);
      calm = 1'b1;
      tick(2);
      chk(oalm, 1'b1);
      calm = 1'b0;
      chk(est, 16'h0008);
      chk(orem, 1'b1);
      alm = 1'b1;
      tick(2);
      chk(oalm, 1'b1);
      xchg(16'ha000);
      chk(sst, 16'h8000);
      xchg(16'h4000);
      chk(sst, 16'h4000);
      chk(fact, 32'h0);
      chk(orem, 1'b0);
      flt = 32'h0;
      v41 = 1'b1;
      tick(2);
      chk(est[ESW_CTRL_REQ], 1'b1);
      xchg(16'h0000);
      deny = 1'b1;
      xchg(16'h1800);
      chk(off, 32'h389);
      deny = 1'b0;
      xchg(16'h1800);
      chk(off, 32'h38e);
      chk(ostab, 1'b1);
      bad = 1'b1;
      repeat (4) xchg(16'h1800);
      chk(ostab, 1'b0);
      rst = 1'b1;
      tick(2);
      chk(sst, 16'h4000);
      chk(off, 32'h0);
      rst = 1'b0;
      tick(1);
      chk(sst, 16'h0000);
      end_sim();
   end
endmodule : epcs_core_test
`default_nettype wire

// ===== epcs_life_mon.sv
// Controller sign-of-life monitor, one step per cyclic exchange
`timescale 1ns/100ps
`default_nettype none
module epcs_life_mon
   import epcs_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_srst,
   input wire logic i_step,
   input wire logic [3:0] i_life,
   output logic o_stable
);
   typedef struct packed {
      logic [3:0] last;
      logic [3:0] miss;
      logic seen;
      logic stable;
   } epcs_life_t;
   epcs_life_t s_q, s_d;

   always_comb begin
      s_d = s_q;
      if (i_step) begin
         s_d.seen = 1'b1;
         s_d.last = i_life;
         // A count that moves on by one counts as good; anything else after the first step is a miss
         if (s_q.seen && (i_life == s_q.last + 4'h1)) begin
            s_d.miss = 4'h0;
         end else if (s_q.seen && s_q.miss < LIFE_MISS_LIMIT) begin
            s_d.miss = s_q.miss + 4'h1;
         end
         s_d.stable = s_q.seen && (s_d.miss < LIFE_MISS_LIMIT);
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_stable = s_q.stable;

   life_bound_a: assert property (@(posedge i_mclk) disable iff (i_srst) s_q.miss <= LIFE_MISS_LIMIT)
      else $error("life miss count out of range");
endmodule : epcs_life_mon
`default_nettype wire

// ===== epcs_pkg.sv
// Package with constants for the encoder profile control and status block
package epcs_pkg;
   // Operating status flag positions
   localparam int OPS_CODE_SEQ = 0;
   localparam int OPS_EXT_CLASS = 1;
   localparam int OPS_PRESET_INH = 2;
   localparam int OPS_SCALING = 3;
   localparam int OPS_ALARM_ENC = 4;
   localparam int OPS_COMPAT_OFF = 5;
   // Sensor control word bit positions
   localparam int SCW_MODE = 11;
   localparam int SCW_REQ = 12;
   localparam int SCW_ABS = 13;
   localparam int SCW_PARK = 14;
   localparam int SCW_ACK = 15;
   // Sensor status word bit positions
   localparam int SSW_ACKREQ = 11;
   localparam int SSW_DONE = 12;
   localparam int SSW_ABS = 13;
   localparam int SSW_PARK = 14;
   localparam int SSW_ERR = 15;
   // Encoder control and status word positions
   localparam int ECW_LIFE_LO = 12;
   localparam int ECW_PLC = 10;
   localparam int ESW_CTRL_REQ = 9;
   localparam int ESW_FAULT = 3;
   // Masks of used control bits
   localparam logic [15:0] SCW_USED_MASK = 16'hf800;
   localparam logic [15:0] ECW_USED_MASK = 16'hf400;
   // Supported fault set
   localparam logic [31:0] FAULTS_SUPPORTED = 32'h00000031;
   // Reset values and sign-of-life miss limit
   localparam logic [31:0] OFFSET_RST = 32'h00000000;
   localparam logic [15:0] WORD_RST = 16'h0000;
   localparam logic [3:0] LIFE_MISS_LIMIT = 4'h3;
endpackage : epcs_pkg

// ===== epcs_plc_model.sv
// Controller-side partner model: cyclic exchanges, sign-of-life and control reply
`timescale 1ns/100ps
`default_nettype none
module epcs_plc_model (
   input wire logic i_mclk,
   input wire logic i_go,
   input wire logic [15:0] i_scw,
   input wire logic i_ctrl_req,
   input wire logic i_deny,
   input wire logic i_life_bad,
   output logic o_exchange,
   output logic [15:0] o_sensor_ctrl,
   output logic [15:0] o_encoder_ctrl
);
   logic take;
   logic [3:0] life;
   initial begin
      o_exchange = 1'b0;
      o_sensor_ctrl = 16'h0000;
      o_encoder_ctrl = 16'h0000;
      life = 4'h0;
   end
   // Request sampled on the edge itself, so the bench may change it 1 ns later
   always @(posedge i_mclk) begin
      take = i_go;
      #1;
      o_exchange = take;
      if (take) begin
         if (!i_life_bad) begin
            life = life + 4'h1;
         end
         o_sensor_ctrl = i_scw;
         // Unused bits toggle every exchange so that ignoring them is really tested
         o_encoder_ctrl = {life, ~o_encoder_ctrl[11], i_ctrl_req && !i_deny, ~o_encoder_ctrl[9:0]};
      end
   end
endmodule : epcs_plc_model
`default_nettype wire
